/* logic/ocr_class_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ocr_class_if;
  import ocr_pkg::*;
  logic [OCR_REQ_W-1:0] req_vec; // one-hot request class, register bit order
  logic [OCR_RSP_W-1:0] rsp_vec; // at most one response class set, bit 0 is register bit 8
  modport source (output req_vec, output rsp_vec);
  modport sink (input req_vec, input rsp_vec);
endinterface : ocr_class_if
`default_nettype wire

/* logic/ocr_classify.sv */
`timescale 1ns/1ps
`default_nettype none
module ocr_classify
  import ocr_pkg::*;
(
  input wire ocr_req_kind_e req_kind,
  input wire logic from_l2_prefetch,
  input wire ocr_rsp_kind_e rsp_kind,
  input wire logic home_local,
  ocr_class_if.source cls
);
  // request decode, prefetcher origin splits data, ownership and code reads in two
  always_comb begin
    cls.req_vec = '0;
    unique case (req_kind)
      OCR_REQ_DATA_READ: begin
        if (from_l2_prefetch) begin
          cls.req_vec[OCR_REQ_PF_DATA_BIT] = 1'b1;
        end else begin
          cls.req_vec[OCR_REQ_DEMAND_DATA_BIT] = 1'b1;
        end
      end
      // table walks are never prefetches
      OCR_REQ_TABLE_READ: cls.req_vec[OCR_REQ_DEMAND_DATA_BIT] = 1'b1;
      OCR_REQ_OWN_READ: begin
        if (from_l2_prefetch) begin
          cls.req_vec[OCR_REQ_PF_OWN_BIT] = 1'b1;
        end else begin
          cls.req_vec[OCR_REQ_DEMAND_OWN_BIT] = 1'b1;
        end
      end
      OCR_REQ_CODE_READ: begin
        if (from_l2_prefetch) begin
          cls.req_vec[OCR_REQ_PF_CODE_BIT] = 1'b1;
        end else begin
          cls.req_vec[OCR_REQ_DEMAND_CODE_BIT] = 1'b1;
        end
      end
      OCR_REQ_WRITEBACK: cls.req_vec[OCR_REQ_WRITEBACK_BIT] = 1'b1;
      OCR_REQ_MISC: cls.req_vec[OCR_REQ_MISC_BIT] = 1'b1;
      default: cls.req_vec = '0; // undefined code qualifies nothing
    endcase
  end

  // response decode, home location splits misses
  always_comb begin
    cls.rsp_vec = '0;
    unique case (rsp_kind)
      OCR_RSP_HIT_NOSNOOP: cls.rsp_vec[OCR_RSP_NOSNOOP_BIT-OCR_RSP_LSB] = 1'b1;
      OCR_RSP_HIT_PEER_CLEAN: cls.rsp_vec[OCR_RSP_PEER_CLEAN_BIT-OCR_RSP_LSB] = 1'b1;
      OCR_RSP_HIT_PEER_MOD: cls.rsp_vec[OCR_RSP_PEER_MOD_BIT-OCR_RSP_LSB] = 1'b1;
      OCR_RSP_MISS_FORWARD: begin
        // remotely homed forwards fall in no class
        cls.rsp_vec[OCR_RSP_FORWARD_BIT-OCR_RSP_LSB] = home_local;
      end
      OCR_RSP_MISS_MEMORY: begin
        cls.rsp_vec[OCR_RSP_LOCAL_MEM_BIT-OCR_RSP_LSB] = home_local;
        cls.rsp_vec[OCR_RSP_REMOTE_MEM_BIT-OCR_RSP_LSB] = !home_local;
      end
      OCR_RSP_IO_HUB: cls.rsp_vec[OCR_RSP_IO_HUB_BIT-OCR_RSP_LSB] = 1'b1;
      OCR_RSP_UNCLASSED: cls.rsp_vec = '0;
      default: cls.rsp_vec = '0; // undefined code qualifies nothing
    endcase
  end
endmodule : ocr_classify
`default_nettype wire

/* logic/ocr_event_filter.sv */
`timescale 1ns/1ps
`default_nettype none
module ocr_event_filter
  import ocr_pkg::*;
#(
  parameter int NUM_SEL = 2,
  parameter int ADDR_W = 32,
  parameter logic [31:0] SEL1_ADDR = OCR_SEL1_ADDR_DEFAULT
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [OCR_SEL_W-1:0] reg_wdata,
  output logic [OCR_SEL_W-1:0] reg_rdata,
  output logic reg_rd_valid,
  output logic reg_fault,
  input wire logic txn_valid,
  input wire ocr_req_kind_e txn_req_kind,
  input wire logic txn_from_l2_prefetch,
  input wire ocr_rsp_kind_e txn_rsp_kind,
  input wire logic txn_home_local,
  output logic [NUM_SEL-1:0] offcore_event
);
  // elaboration guards: two select registers, address must hold both
  if (NUM_SEL != 2) begin : g_bad_num
    $error("ocr_event_filter: NUM_SEL must be 2");
  end
  if (ADDR_W < 9 || ADDR_W > 32) begin : g_bad_addr
    $error("ocr_event_filter: ADDR_W must be 9 to 32");
  end

  // select register storage, one word per counter
  logic [OCR_SEL_W-1:0] sel_reg [NUM_SEL];
  // address decode per register
  logic [NUM_SEL-1:0] addr_hit;
  // raw match per register, before the output flop
  logic [NUM_SEL-1:0] match;
  // decoded class vectors from the classifier
  ocr_class_if cls ();
  // read data mux result
  logic [OCR_SEL_W-1:0] rd_mux;

  // decode of the transaction kinds into one-hot classes
  ocr_classify u_classify (
    .req_kind(txn_req_kind),
    .from_l2_prefetch(txn_from_l2_prefetch),
    .rsp_kind(txn_rsp_kind),
    .home_local(txn_home_local),
    .cls(cls.source)
  );

  // register addresses, full width compare
  assign addr_hit[0] = (reg_addr == OCR_SEL0_ADDR[ADDR_W-1:0]);
  assign addr_hit[1] = (reg_addr == SEL1_ADDR[ADDR_W-1:0]);

  // per register storage and qualification
  for (genvar i = 0; i < NUM_SEL; i++) begin : g_sel
    // software write; reserved bit kept as written but never used
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        sel_reg[i] <= OCR_SEL_RESET;
      end else if (reg_wr_en && addr_hit[i]) begin
        sel_reg[i] <= reg_wdata;
      end
    end

    // both halves must agree; bit11 masked so it cannot qualify
    assign match[i] = txn_valid
      && |(cls.req_vec & sel_reg[i][OCR_REQ_MSB:OCR_REQ_LSB])
      && |(cls.rsp_vec & sel_reg[i][OCR_RSP_MSB:OCR_RSP_LSB]
           & OCR_RSP_USABLE_MASK);

    // one registered pulse per qualifying transaction
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        offcore_event[i] <= 1'b0;
      end else begin
        offcore_event[i] <= match[i];
      end
    end
  end

  // read data select, zero when unmapped
  always_comb begin
    rd_mux = '0;
    for (int j = 0; j < NUM_SEL; j++) begin
      if (addr_hit[j]) begin
        rd_mux = sel_reg[j];
      end
    end
  end

  // read answer one cycle after the request
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      // hold last data between reads so software sees a stable value
      if (reg_rd_en) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // unmapped access flag, pulse for one cycle, write dropped
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_fault <= 1'b0;
    end else begin
      reg_fault <= (reg_wr_en || reg_rd_en) && !(|addr_hit);
    end
  end

  // checks on the class decode
  chk_req_demand_data: assert property (@(posedge clock) disable iff (!resetn)
    ((txn_req_kind == OCR_REQ_TABLE_READ) ||
     (txn_req_kind == OCR_REQ_DATA_READ && !txn_from_l2_prefetch))
    |-> cls.req_vec[OCR_REQ_DEMAND_DATA_BIT] && !cls.req_vec[OCR_REQ_PF_DATA_BIT])
    else $error("demand data read not decoded to bit 0");

  chk_req_demand_own: assert property (@(posedge clock) disable iff (!resetn)
    cls.req_vec[OCR_REQ_DEMAND_OWN_BIT]
    == (txn_req_kind == OCR_REQ_OWN_READ && !txn_from_l2_prefetch))
    else $error("demand ownership read decode wrong");

  chk_req_demand_code: assert property (@(posedge clock) disable iff (!resetn)
    cls.req_vec[OCR_REQ_DEMAND_CODE_BIT]
    == (txn_req_kind == OCR_REQ_CODE_READ && !txn_from_l2_prefetch))
    else $error("demand code read decode wrong");

  chk_req_writeback: assert property (@(posedge clock) disable iff (!resetn)
    cls.req_vec[OCR_REQ_WRITEBACK_BIT] == (txn_req_kind == OCR_REQ_WRITEBACK))
    else $error("writeback decode wrong");

  chk_req_prefetch: assert property (@(posedge clock) disable iff (!resetn)
    txn_from_l2_prefetch && (txn_req_kind == OCR_REQ_DATA_READ)
    |-> cls.req_vec[OCR_REQ_PF_DATA_BIT] && $onehot(cls.req_vec))
    else $error("prefetcher data read decode wrong");

  chk_req_pf_own: assert property (@(posedge clock) disable iff (!resetn)
    cls.req_vec[OCR_REQ_PF_OWN_BIT]
    == (txn_req_kind == OCR_REQ_OWN_READ && txn_from_l2_prefetch))
    else $error("prefetcher ownership read decode wrong");

  chk_req_pf_code: assert property (@(posedge clock) disable iff (!resetn)
    cls.req_vec[OCR_REQ_PF_CODE_BIT]
    == (txn_req_kind == OCR_REQ_CODE_READ && txn_from_l2_prefetch))
    else $error("prefetcher code read decode wrong");

  chk_req_misc: assert property (@(posedge clock) disable iff (!resetn)
    cls.req_vec[OCR_REQ_MISC_BIT] == (txn_req_kind == OCR_REQ_MISC))
    else $error("miscellaneous decode wrong");

  chk_rsp_hits: assert property (@(posedge clock) disable iff (!resetn)
    (cls.rsp_vec[OCR_RSP_NOSNOOP_BIT-OCR_RSP_LSB] == (txn_rsp_kind == OCR_RSP_HIT_NOSNOOP))
    && (cls.rsp_vec[OCR_RSP_PEER_CLEAN_BIT-OCR_RSP_LSB]
        == (txn_rsp_kind == OCR_RSP_HIT_PEER_CLEAN))
    && (cls.rsp_vec[OCR_RSP_PEER_MOD_BIT-OCR_RSP_LSB]
        == (txn_rsp_kind == OCR_RSP_HIT_PEER_MOD)))
    else $error("outer hit response decode wrong");

  chk_rsp_forward: assert property (@(posedge clock) disable iff (!resetn)
    cls.rsp_vec[OCR_RSP_FORWARD_BIT-OCR_RSP_LSB]
    == (txn_rsp_kind == OCR_RSP_MISS_FORWARD && txn_home_local))
    else $error("forwarded miss decode wrong");

  chk_rsp_memory: assert property (@(posedge clock) disable iff (!resetn)
    (txn_rsp_kind == OCR_RSP_MISS_MEMORY)
    |-> (cls.rsp_vec[OCR_RSP_LOCAL_MEM_BIT-OCR_RSP_LSB] == txn_home_local)
        && (cls.rsp_vec[OCR_RSP_REMOTE_MEM_BIT-OCR_RSP_LSB] == !txn_home_local))
    else $error("memory miss decode wrong");

  chk_rsp_io_hub: assert property (@(posedge clock) disable iff (!resetn)
    cls.rsp_vec[OCR_RSP_IO_HUB_BIT-OCR_RSP_LSB] == (txn_rsp_kind == OCR_RSP_IO_HUB))
    else $error("hub response decode wrong");

  chk_rsp_reserved: assert property (@(posedge clock) disable iff (!resetn)
    !cls.rsp_vec[OCR_RSP_RESERVED_BIT-OCR_RSP_LSB])
    else $error("reserved response class decoded");

  // checks on the event outputs, tied to the register contents
  chk_event_both_match: assert property (@(posedge clock) disable iff (!resetn)
    offcore_event[0] |->
      $past(txn_valid)
      && |($past(cls.req_vec) & $past(sel_reg[0][OCR_REQ_MSB:OCR_REQ_LSB]))
      && |($past(cls.rsp_vec) & $past(sel_reg[0][OCR_RSP_MSB:OCR_RSP_LSB])
           & OCR_RSP_USABLE_MASK))
    else $error("event 0 without a request and response match");

  chk_event_no_miss: assert property (@(posedge clock) disable iff (!resetn)
    txn_valid && |(cls.req_vec & sel_reg[1][OCR_REQ_MSB:OCR_REQ_LSB])
    && |(cls.rsp_vec & sel_reg[1][OCR_RSP_MSB:OCR_RSP_LSB] & OCR_RSP_USABLE_MASK)
    |=> offcore_event[1])
    else $error("qualifying transaction lost on event 1");

  chk_event_idle: assert property (@(posedge clock) disable iff (!resetn)
    !txn_valid |=> offcore_event == '0)
    else $error("event without a transaction");

  chk_reserved_only: assert property (@(posedge clock) disable iff (!resetn)
    (sel_reg[0][OCR_RSP_MSB:OCR_RSP_LSB] == 8'h08) |=> !offcore_event[0])
    else $error("reserved response bit qualified an event");

  chk_sel_write: assert property (@(posedge clock) disable iff (!resetn)
    reg_wr_en && addr_hit[0] |=> sel_reg[0] == $past(reg_wdata))
    else $error("select 0 write not stored");

  chk_read_back: assert property (@(posedge clock) disable iff (!resetn)
    reg_rd_en && addr_hit[1] && !reg_wr_en |=> reg_rd_valid && (reg_rdata == sel_reg[1]))
    else $error("select 1 read data wrong");

  chk_unmapped_fault: assert property (@(posedge clock) disable iff (!resetn)
    reg_rd_en && !(|addr_hit) |=> reg_fault && reg_rdata == '0 ##1 !reg_fault [*2])
    else $error("unmapped read not answered");

  // select 1 mirrors of the event checks, so a broken lane cannot hide
  chk_event_match_1: assert property (@(posedge clock) disable iff (!resetn)
    offcore_event[1] |->
      $past(txn_valid)
      && |($past(cls.req_vec) & $past(sel_reg[1][OCR_REQ_MSB:OCR_REQ_LSB]))
      && |($past(cls.rsp_vec) & $past(sel_reg[1][OCR_RSP_MSB:OCR_RSP_LSB])
           & OCR_RSP_USABLE_MASK))
    else $error("event 1 without a request and response match");

  // a qualifying transaction on select 0 must not be dropped
  chk_event_keep_0: assert property (@(posedge clock) disable iff (!resetn)
    txn_valid && |(cls.req_vec & sel_reg[0][OCR_REQ_MSB:OCR_REQ_LSB])
    && |(cls.rsp_vec & sel_reg[0][OCR_RSP_MSB:OCR_RSP_LSB] & OCR_RSP_USABLE_MASK)
    |=> offcore_event[0])
    else $error("qualifying transaction lost on event 0");

  // bit 11 alone on select 1 must stay silent too
  chk_reserved_only_1: assert property (@(posedge clock) disable iff (!resetn)
    (sel_reg[1][OCR_RSP_MSB:OCR_RSP_LSB] == 8'h08) |=> !offcore_event[1])
    else $error("reserved response bit qualified event 1");

  // select 1 takes a mapped write whole
  chk_sel1_write: assert property (@(posedge clock) disable iff (!resetn)
    reg_wr_en && addr_hit[1] |=> sel_reg[1] == $past(reg_wdata))
    else $error("select 1 write not stored");

  // select 0 reads back what it holds
  chk_read_back_0: assert property (@(posedge clock) disable iff (!resetn)
    reg_rd_en && addr_hit[0] && !reg_wr_en |=> reg_rd_valid && (reg_rdata == sel_reg[0]))
    else $error("select 0 read data wrong");

  // read and write together: the read sees the old word
  chk_read_old_value: assert property (@(posedge clock) disable iff (!resetn)
    reg_rd_en && reg_wr_en && addr_hit[0] |=> reg_rdata == $past(sel_reg[0]))
    else $error("same cycle read did not return old value");

  // read valid is exactly one cycle per strobe
  chk_rd_valid_pulse: assert property (@(posedge clock) disable iff (!resetn)
    reg_rd_valid == $past(reg_rd_en))
    else $error("read valid not one cycle after strobe");

  // read data holds between reads; software may sample late
  chk_rdata_hold: assert property (@(posedge clock) disable iff (!resetn)
    !reg_rd_en |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  // unmapped write is dropped and flagged
  chk_unmapped_write: assert property (@(posedge clock) disable iff (!resetn)
    reg_wr_en && !(|addr_hit)
    |=> reg_fault && $stable(sel_reg[0]) && $stable(sel_reg[1]))
    else $error("unmapped write not dropped");

  // mapped accesses never raise the fault flag
  chk_mapped_no_fault: assert property (@(posedge clock) disable iff (!resetn)
    (reg_wr_en || reg_rd_en) && (|addr_hit) |=> !reg_fault)
    else $error("fault on a mapped access");

  // selects change only through a write
  chk_sel_hold: assert property (@(posedge clock) disable iff (!resetn)
    !reg_wr_en |=> $stable(sel_reg[0]) && $stable(sel_reg[1]))
    else $error("select changed without a write");

  // every defined request kind lands in exactly one class
  chk_req_onehot: assert property (@(posedge clock) disable iff (!resetn)
    (txn_req_kind inside {[OCR_REQ_DATA_READ:OCR_REQ_MISC]}) |-> $onehot(cls.req_vec))
    else $error("request kind not one-hot");

  // table walks count as demand data even when flagged prefetch
  chk_req_table: assert property (@(posedge clock) disable iff (!resetn)
    (txn_req_kind == OCR_REQ_TABLE_READ)
    |-> cls.req_vec[OCR_REQ_DEMAND_DATA_BIT] && $onehot(cls.req_vec))
    else $error("table read decode wrong");

  // at most one response class per transaction
  chk_rsp_onehot0: assert property (@(posedge clock) disable iff (!resetn)
    $onehot0(cls.rsp_vec))
    else $error("more than one response class");

  // replies outside the table qualify nothing
  chk_rsp_unclassed: assert property (@(posedge clock) disable iff (!resetn)
    (txn_rsp_kind == OCR_RSP_UNCLASSED) |-> cls.rsp_vec == '0)
    else $error("unclassed reply decoded");

  // main scenarios
  cov_event_demand: cover property (@(posedge clock) disable iff (!resetn)
    txn_valid && cls.req_vec[OCR_REQ_DEMAND_DATA_BIT] ##1 offcore_event[0]);
  cov_event_both: cover property (@(posedge clock) disable iff (!resetn)
    offcore_event == 2'b11);
  cov_write_then_event: cover property (@(posedge clock) disable iff (!resetn)
    reg_wr_en && addr_hit[1] ##[1:20] offcore_event[1]);
  cov_fault: cover property (@(posedge clock) disable iff (!resetn)
    reg_fault);
  // reserved-only select seeing traffic
  cov_reserved_quiet: cover property (@(posedge clock) disable iff (!resetn)
    txn_valid && (sel_reg[0][OCR_RSP_MSB:OCR_RSP_LSB] == 8'h08));
endmodule : ocr_event_filter
`default_nettype wire

/* logic/ocr_pkg.sv */
`default_nettype none
package ocr_pkg;
  // register access addresses
  localparam logic [31:0] OCR_SEL0_ADDR = 32'h0000_01a6;
  localparam logic [31:0] OCR_SEL1_ADDR_DEFAULT = 32'h0000_01a7;
  // register width and reset value
  localparam int OCR_SEL_W = 16;
  localparam logic [15:0] OCR_SEL_RESET = 16'h0000;
  // field layout
  localparam int OCR_REQ_LSB = 0;
  localparam int OCR_REQ_MSB = 7;
  localparam int OCR_RSP_LSB = 8;
  localparam int OCR_RSP_MSB = 15;
  localparam int OCR_REQ_W = OCR_REQ_MSB - OCR_REQ_LSB + 1;
  localparam int OCR_RSP_W = OCR_RSP_MSB - OCR_RSP_LSB + 1;
  // request field bit positions
  localparam int OCR_REQ_DEMAND_DATA_BIT = 0;
  localparam int OCR_REQ_DEMAND_OWN_BIT = 1;
  localparam int OCR_REQ_DEMAND_CODE_BIT = 2;
  localparam int OCR_REQ_WRITEBACK_BIT = 3;
  localparam int OCR_REQ_PF_DATA_BIT = 4;
  localparam int OCR_REQ_PF_OWN_BIT = 5;
  localparam int OCR_REQ_PF_CODE_BIT = 6;
  localparam int OCR_REQ_MISC_BIT = 7;
  // response field bit positions
  localparam int OCR_RSP_NOSNOOP_BIT = 8;
  localparam int OCR_RSP_PEER_CLEAN_BIT = 9;
  localparam int OCR_RSP_PEER_MOD_BIT = 10;
  localparam int OCR_RSP_RESERVED_BIT = 11;
  localparam int OCR_RSP_FORWARD_BIT = 12;
  localparam int OCR_RSP_REMOTE_MEM_BIT = 13;
  localparam int OCR_RSP_LOCAL_MEM_BIT = 14;
  localparam int OCR_RSP_IO_HUB_BIT = 15;
  // response bits that take part in matching
  localparam logic [7:0] OCR_RSP_USABLE_MASK = 8'hf7;
  // request classes seen on the core request stream
  typedef enum logic [2:0] {
    OCR_REQ_DATA_READ,
    OCR_REQ_TABLE_READ,
    OCR_REQ_OWN_READ,
    OCR_REQ_CODE_READ,
    OCR_REQ_WRITEBACK,
    OCR_REQ_MISC
  } ocr_req_kind_e;
  // response classes returned by the outer subsystem
  typedef enum logic [2:0] {
    OCR_RSP_HIT_NOSNOOP,
    OCR_RSP_HIT_PEER_CLEAN,
    OCR_RSP_HIT_PEER_MOD,
    OCR_RSP_MISS_FORWARD,
    OCR_RSP_MISS_MEMORY,
    OCR_RSP_IO_HUB,
    OCR_RSP_UNCLASSED
  } ocr_rsp_kind_e;
endpackage : ocr_pkg
`default_nettype wire

/* sim/ocr_outer_model.sv */
`timescale 1ns/1ps
`default_nettype none
// far-side stand-in: the outer cache and memory returning a reply class
module ocr_outer_model
  import ocr_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic active,
  input wire ocr_rsp_kind_e want_kind,
  input wire logic want_local,
  output ocr_rsp_kind_e rsp_kind,
  output logic home_local
);
  logic [2:0] idle_reg; // scramble source for idle cycles
  // step the scramble every cycle so a stale reply never lingers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      idle_reg <= 3'h0;
    end else begin
      idle_reg <= idle_reg + 3'h3;
    end
  end
  // reply holds only while a transaction is presented
  always_comb begin
    if (active) begin
      rsp_kind = want_kind;
      home_local = want_local;
    end else begin
      // no real reply: show junk rather than the last value
      rsp_kind = ocr_rsp_kind_e'(idle_reg);
      home_local = idle_reg[0];
    end
  end
endmodule : ocr_outer_model
`default_nettype wire

/* sim/offcore_response_event_filter_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module offcore_response_event_filter_tb_top;
  import ocr_pkg::*;
  localparam logic [31:0] BAD_ADDR = 32'h0000_01a8; // unmapped
  // request table: kind [7:5], prefetch flag [4], mask bit [3:0]
  localparam logic [7:0] REQ_TAB [12] = '{8'h00, 8'h20, 8'h30, 8'h41, 8'h62, 8'h83,
                                          8'h93, 8'h14, 8'h55, 8'h76, 8'ha7, 8'hb7};
  // response table: kind [7:5], local [4], bit minus 8 [3:0], f means none
  localparam logic [7:0] RSP_TAB [9] = '{8'h00, 8'h21, 8'h42, 8'h74, 8'h6f, 8'h96,
                                         8'h85, 8'hb7, 8'hdf};
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [31:0] reg_addr = 32'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic [15:0] reg_rdata;
  logic reg_rd_valid;
  logic reg_fault;
  logic txn_valid = 1'b0;
  ocr_req_kind_e txn_req_kind = OCR_REQ_DATA_READ;
  logic txn_pf = 1'b0;
  ocr_rsp_kind_e want_kind = OCR_RSP_HIT_NOSNOOP;
  logic want_local = 1'b0;
  ocr_rsp_kind_e txn_rsp_kind; // from the far-side model
  logic txn_home_local;
  logic [1:0] offcore_event;
  int errors = 0;
  int checks_done = 0;
  // 50 MHz core clock
  always #10 clock = ~clock;
  ocr_event_filter ocr_event_filter_i (
    .clock(clock), .resetn(resetn), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .reg_fault(reg_fault), .txn_valid(txn_valid),
    .txn_req_kind(txn_req_kind), .txn_from_l2_prefetch(txn_pf),
    .txn_rsp_kind(txn_rsp_kind), .txn_home_local(txn_home_local),
    .offcore_event(offcore_event));
  ocr_outer_model ocr_outer_model_i (
    .clock(clock), .resetn(resetn), .active(txn_valid), .want_kind(want_kind),
    .want_local(want_local), .rsp_kind(txn_rsp_kind), .home_local(txn_home_local));
  // compare a register word
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp_word
  // compare a pair of flags
  task automatic cmp_flags(input logic [1:0] got, input logic [1:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : cmp_flags
  // one write; the leading wait keeps strobe edges in separate time steps
  task automatic reg_write(input logic [31:0] addr, input logic [15:0] data, input logic flt);
    @(negedge clock);
    reg_wr_en = 1'b1;
    reg_addr = addr;
    reg_wdata = data;
    @(negedge clock);
    reg_wr_en = 1'b0;
    cmp_flags({reg_rd_valid, reg_fault}, {1'b0, flt}, "write answer");
  endtask : reg_write
  // one read, answer judged in the single cycle it stands
  task automatic reg_read(input logic [31:0] addr, input logic [15:0] exp, input logic flt);
    @(negedge clock);
    reg_rd_en = 1'b1;
    reg_addr = addr;
    @(negedge clock);
    reg_rd_en = 1'b0;
    cmp_flags({reg_rd_valid, reg_fault}, {1'b1, flt}, "read answer");
    cmp_word(reg_rdata, exp, "read data");
  endtask : reg_read
  // one transaction, event pulse judged one cycle later
  task automatic send_txn(input ocr_req_kind_e rq, input logic pf, input ocr_rsp_kind_e rs,
                          input logic loc, input logic [1:0] exp);
    @(negedge clock);
    txn_valid = 1'b1;
    txn_req_kind = rq;
    txn_pf = pf;
    want_kind = rs;
    want_local = loc;
    @(negedge clock);
    txn_valid = 1'b0;
    cmp_flags(offcore_event, exp, "event pulse");
  endtask : send_txn
  // reset values, readback of both selects, unmapped access
  task automatic test_regs;
    reg_read(OCR_SEL0_ADDR, OCR_SEL_RESET, 1'b0);
    reg_read(OCR_SEL1_ADDR_DEFAULT, OCR_SEL_RESET, 1'b0);
    reg_write(OCR_SEL0_ADDR, 16'ha5c3, 1'b0);
    reg_write(OCR_SEL1_ADDR_DEFAULT, 16'h5a3c, 1'b0);
    reg_write(BAD_ADDR, 16'hffff, 1'b1);
    reg_read(OCR_SEL0_ADDR, 16'ha5c3, 1'b0);
    reg_read(OCR_SEL1_ADDR_DEFAULT, 16'h5a3c, 1'b0);
    reg_read(BAD_ADDR, 16'h0000, 1'b1);
  endtask : test_regs
  // each request class must hit its own bit and no other
  task automatic test_requests;
    logic [7:0] hot;
    foreach (REQ_TAB[i]) begin
      hot = 8'h01 << REQ_TAB[i][3:0];
      reg_write(OCR_SEL0_ADDR, {8'hff, hot}, 1'b0);
      reg_write(OCR_SEL1_ADDR_DEFAULT, {8'hff, ~hot}, 1'b0);
      send_txn(ocr_req_kind_e'(REQ_TAB[i][7:5]), REQ_TAB[i][4], OCR_RSP_HIT_NOSNOOP, 1'b1,
               2'b01);
    end
  endtask : test_requests
  // each reply class must hit its own bit; unclassed ones hit nothing
  task automatic test_responses;
    logic none;
    logic [7:0] hot;
    foreach (RSP_TAB[i]) begin
      none = (RSP_TAB[i][3:0] == 4'hf);
      hot = none ? 8'hff : (8'h01 << RSP_TAB[i][2:0]);
      reg_write(OCR_SEL0_ADDR, {hot, 8'h01}, 1'b0);
      reg_write(OCR_SEL1_ADDR_DEFAULT, {none ? 8'hff : ~hot, 8'h01}, 1'b0);
      send_txn(OCR_REQ_DATA_READ, 1'b0, ocr_rsp_kind_e'(RSP_TAB[i][7:5]), RSP_TAB[i][4],
               {1'b0, ~none});
    end
  endtask : test_responses
  // bit 11 alone, and a reply mask with no request mask, both stay silent
  task automatic test_reserved;
    reg_write(OCR_SEL0_ADDR, 16'h0801, 1'b0);
    reg_write(OCR_SEL1_ADDR_DEFAULT, 16'hff00, 1'b0);
    reg_read(OCR_SEL0_ADDR, 16'h0801, 1'b0);
    for (int r = 0; r < 7; r++) begin
      send_txn(OCR_REQ_DATA_READ, 1'b0, ocr_rsp_kind_e'(r[2:0]), r[0], 2'b00);
    end
  endtask : test_reserved
  // three transactions back to back, middle one misses its request bit
  task automatic test_back_to_back;
    reg_write(OCR_SEL0_ADDR, 16'h4001, 1'b0);
    reg_write(OCR_SEL1_ADDR_DEFAULT, 16'h0000, 1'b0);
    @(negedge clock);
    txn_valid = 1'b1;
    want_kind = OCR_RSP_MISS_MEMORY;
    want_local = 1'b1;
    txn_req_kind = OCR_REQ_DATA_READ;
    @(negedge clock);
    cmp_flags(offcore_event, 2'b01, "burst first");
    txn_req_kind = OCR_REQ_OWN_READ;
    @(negedge clock);
    cmp_flags(offcore_event, 2'b00, "burst second");
    txn_req_kind = OCR_REQ_DATA_READ;
    @(negedge clock);
    txn_valid = 1'b0;
    cmp_flags(offcore_event, 2'b01, "burst third");
  endtask : test_back_to_back
  // verdict and end of run
  task automatic final_report;
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  // hang guard, far above the real run length
  initial begin
    repeat (5000) @(posedge clock);
    errors++;
    $display("[FAIL] %0t run limit reached", $time);
    final_report();
  end
  // main sequence, reset held for ten cycles
  initial begin
    repeat (10) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    test_regs();
    test_requests();
    test_responses();
    test_reserved();
    test_back_to_back();
    final_report();
  end
endmodule : offcore_response_event_filter_tb_top
`default_nettype wire
